// [tcs_pkg.sv]
// package: constants for the timeslot conditioning and signalling banks
package tcs_pkg;
    // =====================================================================
    // geometry
    localparam int unsigned MAX_PORTS   = 8;
    localparam int unsigned NUM_TS      = 32;
    localparam int unsigned ENTRIES     = MAX_PORTS * NUM_TS;
    localparam int unsigned ADDR_W      = 20;
    localparam int unsigned SEL_W       = 2;
    localparam int unsigned SIG_W       = 4;
    localparam int unsigned OCTET_W     = 8;
    // =====================================================================
    // address map
    localparam logic [19:0] COND_BASE   = 20'h50000;
    localparam logic [19:0] SIG_BASE    = 20'h58000;
    localparam logic [19:0] PORT_STRIDE = 20'h00080;
    localparam logic [19:0] WORD_STRIDE = 20'h00004;
    localparam logic [19:0] BANK_SPAN   = 20'h00400;
    // bank select is the address above one bank span
    localparam logic [9:0]  COND_PAGE   = COND_BASE[19:10];
    localparam logic [9:0]  SIG_PAGE    = SIG_BASE[19:10];
    // =====================================================================
    // field positions and reset values
    localparam int unsigned SEL_LSB     = 0;
    localparam int unsigned SIG_LSB     = 0;
    localparam logic [1:0]  SEL_RESET   = 2'h0;
    localparam logic [3:0]  SIG_RESET   = 4'hf;
    // =====================================================================
    // selector encoding
    localparam logic [1:0]  SEL_OCTET_A = 2'h0;
    localparam logic [1:0]  SEL_OCTET_B = 2'h1;
    localparam logic [1:0]  SEL_OCTET_C = 2'h2;
    localparam logic [1:0]  SEL_OCTET_D = 2'h3;
endpackage : tcs_pkg

// [tcs_port_line.sv]
// module: per-port line-side selection of transmit octet and signalling
`timescale 1ns/100ps
module tcs_port_line (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // banks for this port and shared conditioning octets
    input  wire logic [63:0] sel_bank,
    input  wire logic [127:0] sig_bank,
    input  wire logic [31:0] cond_octets,
    // line timeslot context
    input  wire logic [4:0]  ts_index,
    input  wire logic        ts_assigned,
    input  wire logic        sig_assigned,
    input  wire logic        sig_src_sw,
    input  wire logic [7:0]  rx_data,
    input  wire logic [3:0]  rx_sig,
    // line outputs
    output logic      [7:0]  tx_data_out,
    output logic      [3:0]  tx_sig_out
);
    // =====================================================================
    // selection
    logic [1:0] sel;
    logic [7:0] cond_octet;
    logic [3:0] sw_sig;
    logic       use_sw_sig;
    logic [7:0] data_next;
    logic [3:0] sig_next;

    assign sel        = sel_bank[{ts_index, 1'b0} +: 2];
    assign cond_octet = cond_octets[{sel, 3'b000} +: 8];                  // [R3]
    assign sw_sig     = sig_bank[{ts_index, 2'b00} +: 4];                 // [R8]
    // software value covers unassigned, no-signalling and forced timeslots
    assign use_sw_sig = !ts_assigned || !sig_assigned || sig_src_sw;      // [R5] [R9]
    assign data_next  = ts_assigned ? rx_data : cond_octet;               // [R1]
    assign sig_next   = use_sw_sig ? sw_sig : rx_sig;

    // =====================================================================
    // output registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_data_out <= 8'h00;
            tx_sig_out  <= 4'h0;
        end else begin
            tx_data_out <= data_next;
            tx_sig_out  <= sig_next;
        end
    end

    // =====================================================================
    // checks
    property p_cond_out;
        @(posedge clock) disable iff (!rst_n)
        (rst_n && !ts_assigned) |=> tx_data_out == $past(cond_octet);
    endproperty
    a_cond_out: assert property (p_cond_out) else $error("cond octet not driven"); // [R1]

    property p_octet_d;
        @(posedge clock) disable iff (!rst_n)
        (rst_n && !ts_assigned && sel == 2'h3) |=> tx_data_out == $past(cond_octets[31:24]);
    endproperty
    a_octet_d: assert property (p_octet_d) else $error("code 11 not octet d"); // [R3]

    property p_sw_sig;
        @(posedge clock) disable iff (!rst_n)
        // sampled reset keeps the release edge, where outputs still hold reset values, out
        (rst_n && (!ts_assigned || !sig_assigned)) |=> tx_sig_out == $past(sw_sig);
    endproperty
    a_sw_sig: assert property (p_sw_sig) else $error("sw signalling not driven"); // [R5]

    property p_sig_src;
        @(posedge clock) disable iff (!rst_n)
        (rst_n && ts_assigned && sig_assigned) |=>
            tx_sig_out == ($past(sig_src_sw) ? $past(sw_sig) : $past(rx_sig));
    endproperty
    a_sig_src: assert property (p_sig_src) else $error("signalling source wrong"); // [R9]
endmodule : tcs_port_line

// [tcs_bank.sv]
// module: apb register banks for per-timeslot conditioning select and signalling
//
// Behaviour
// R1: per port and timeslot, 2-bit selector picks octet driven when unassigned
// R2: lost-packet fill into jitter buffer uses the same selector's octet
// R3: codes 00/01/10/11 pick octets a/b/c/d; upper bits reserved zero
// R4: selector bank at 0x50000, 0x80 per port from port one, word per timeslot
// R5: software signalling driven when timeslot or its signalling is unassigned
// R6: signalling bank at 0x58000, same port stride and word layout
// R7: timeslots 0 to 31 on up to eight ports; fewer ports keep low entries
// R8: signalling entry holds a four-bit ABCD value in its lowest bits
// R9: assigned timeslot uses software signalling when source setting is one
// R10: software never writes the all-zero signalling pattern
// R11: reads return last written field; software programs entries before use
`timescale 1ns/100ps
module tcs_bank #(
    parameter int unsigned NUM_PORTS = tcs_pkg::MAX_PORTS
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst_n,
    // apb slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [19:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    // conditioning octets a (low byte) to d (high byte)
    input  wire logic [31:0]  cond_octets,
    // line timeslot context, one field per port
    input  wire logic [39:0]  line_ts_index,
    input  wire logic [7:0]   line_ts_assigned,
    input  wire logic [7:0]   line_sig_assigned,
    input  wire logic [7:0]   line_sig_src_sw,
    input  wire logic [63:0]  line_rx_data,
    input  wire logic [31:0]  line_rx_sig,
    // line outputs, one field per port
    output logic      [63:0]  line_tx_data_out,
    output logic      [31:0]  line_tx_signalling_out,
    // jitter buffer lost-packet fill
    input  wire logic         jb_fill_req,
    input  wire logic [2:0]   jb_fill_port,
    input  wire logic [4:0]   jb_fill_ts,
    output logic              jb_fill_valid,
    output logic      [7:0]   jb_fill_octet
);
    // =====================================================================
    // storage
    logic [255:0][1:0] cond_sel_reg;
    logic [255:0][3:0] sw_sig_reg;
    logic [31:0]       prdata_reg;
    logic              pslverr_reg;
    logic              jb_fill_valid_reg;
    logic [7:0]        jb_fill_octet_reg;

    // =====================================================================
    // address decode
    logic [2:0] acc_port;
    logic [4:0] acc_ts;
    logic [7:0] acc_idx;
    logic       hit_cond;
    logic       hit_sig;
    logic       port_ok;
    logic       map_ok;
    logic       setup_ph;
    logic       wr_cond;
    logic       wr_sig;
    logic [31:0] rd_value;

    assign acc_port = paddr[9:7];                                         // [R4] [R6]
    assign acc_ts   = paddr[6:2];
    assign acc_idx  = {acc_port, acc_ts};
    assign hit_cond = paddr[19:10] == tcs_pkg::COND_PAGE;                 // [R4]
    assign hit_sig  = paddr[19:10] == tcs_pkg::SIG_PAGE;                  // [R6]
    // ports at or above the variant's count are absent and answer with an error
    assign port_ok  = 32'(acc_port) < NUM_PORTS;                          // [R7]
    assign map_ok   = (hit_cond || hit_sig) && port_ok && paddr[1:0] == 2'h0;
    assign setup_ph = psel && !penable;
    assign wr_cond  = psel && penable && pwrite && map_ok && hit_cond;
    assign wr_sig   = psel && penable && pwrite && map_ok && hit_sig;
    assign rd_value = !map_ok ? 32'h0 :
                      hit_cond ? {30'h0, cond_sel_reg[acc_idx]} :         // [R11]
                                 {28'h0, sw_sig_reg[acc_idx]};

    // =====================================================================
    // bank writes; reserved bits are dropped
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cond_sel_reg <= {256{tcs_pkg::SEL_RESET}};
            sw_sig_reg   <= {256{tcs_pkg::SIG_RESET}};
        end else begin
            if (wr_cond) begin
                cond_sel_reg[acc_idx] <= pwdata[1:0];                     // [R1] [R3]
            end
            if (wr_sig) begin
                sw_sig_reg[acc_idx] <= pwdata[3:0];                       // [R8]
            end
        end
    end

    // =====================================================================
    // apb answer: read data captured in setup, so zero wait states
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg  <= 32'h0;
            pslverr_reg <= 1'b0;
        end else if (setup_ph) begin
            prdata_reg  <= pwrite ? 32'h0 : rd_value;                     // [R11]
            pslverr_reg <= !map_ok;
        end
    end

    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg && psel && penable;
    assign pready  = 1'b1;

    // =====================================================================
    // jitter buffer fill octet
    logic [7:0] jb_idx;
    logic [1:0] jb_sel;
    logic [7:0] jb_octet;

    assign jb_idx   = {jb_fill_port, jb_fill_ts};
    assign jb_sel   = cond_sel_reg[jb_idx];
    assign jb_octet = cond_octets[{jb_sel, 3'b000} +: 8];                 // [R2]

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            jb_fill_valid_reg <= 1'b0;
            jb_fill_octet_reg <= 8'h00;
        end else begin
            jb_fill_valid_reg <= jb_fill_req;
            if (jb_fill_req) begin
                jb_fill_octet_reg <= jb_octet;                            // [R2]
            end
        end
    end

    assign jb_fill_valid = jb_fill_valid_reg;
    assign jb_fill_octet = jb_fill_octet_reg;

    // =====================================================================
    // line side, one instance per port; absent ports drive zero
    genvar gp;
    generate
        for (gp = 0; gp < 8; gp++) begin : g_port
            if (gp < NUM_PORTS) begin : g_on
                tcs_port_line u_line (
                    .clock       (clock),
                    .rst_n       (rst_n),
                    .sel_bank    (cond_sel_reg[gp*32 +: 32]),
                    .sig_bank    (sw_sig_reg[gp*32 +: 32]),
                    .cond_octets (cond_octets),
                    .ts_index    (line_ts_index[gp*5 +: 5]),
                    .ts_assigned (line_ts_assigned[gp]),
                    .sig_assigned(line_sig_assigned[gp]),
                    .sig_src_sw  (line_sig_src_sw[gp]),
                    .rx_data     (line_rx_data[gp*8 +: 8]),
                    .rx_sig      (line_rx_sig[gp*4 +: 4]),
                    .tx_data_out (line_tx_data_out[gp*8 +: 8]),
                    .tx_sig_out  (line_tx_signalling_out[gp*4 +: 4])
                );                                                        // [R1] [R5] [R7]
            end else begin : g_off
                assign line_tx_data_out[gp*8 +: 8]       = 8'h00;
                assign line_tx_signalling_out[gp*4 +: 4] = 4'h0;
            end
        end
    endgenerate

    // =====================================================================
    // checks
    property p_cond_write;
        @(posedge clock) disable iff (!rst_n)
        wr_cond |=> cond_sel_reg[$past(acc_idx)] == $past(pwdata[1:0]);
    endproperty
    a_cond_write: assert property (p_cond_write) else $error("selector write lost"); // [R1]

    property p_sig_write;
        @(posedge clock) disable iff (!rst_n)
        wr_sig |=> sw_sig_reg[$past(acc_idx)] == $past(pwdata[3:0]);
    endproperty
    a_sig_write: assert property (p_sig_write) else $error("signalling write lost"); // [R8]

    property p_cond_decode;
        @(posedge clock) disable iff (!rst_n)
        (psel && penable && pwrite && port_ok && paddr == 20'h50094)
            |=> cond_sel_reg[37] == $past(pwdata[1:0]);
    endproperty
    a_cond_decode: assert property (p_cond_decode) else $error("selector decode wrong"); // [R4]

    property p_sig_decode;
        @(posedge clock) disable iff (!rst_n)
        (psel && penable && pwrite && port_ok && paddr == 20'h581fc)
            |=> sw_sig_reg[127] == $past(pwdata[3:0]);
    endproperty
    a_sig_decode: assert property (p_sig_decode) else $error("signalling decode wrong"); // [R6]

    property p_readback;
        @(posedge clock) disable iff (!rst_n)
        (setup_ph && !pwrite && map_ok && hit_cond) ##1 (psel && penable)
            |-> prdata == {30'h0, $past(cond_sel_reg[acc_idx])};
    endproperty
    a_readback: assert property (p_readback) else $error("selector readback wrong"); // [R11]

    property p_absent_port;
        @(posedge clock) disable iff (!rst_n)
        (setup_ph && (hit_cond || hit_sig) && !port_ok) ##1 (psel && penable) |-> pslverr;
    endproperty
    a_absent_port: assert property (p_absent_port) else $error("absent port no error"); // [R7]

    property p_jb_fill;
        @(posedge clock) disable iff (!rst_n)
        jb_fill_req |=> jb_fill_valid && jb_fill_octet == $past(jb_octet);
    endproperty
    a_jb_fill: assert property (p_jb_fill) else $error("fill octet wrong"); // [R2]

    property p_octet_a;
        @(posedge clock) disable iff (!rst_n)
        (jb_fill_req && jb_sel == 2'h0) |=> jb_fill_octet == $past(cond_octets[7:0]);
    endproperty
    a_octet_a: assert property (p_octet_a) else $error("code 00 not octet a"); // [R3]
endmodule : tcs_bank

// [tcs_line_model.sv]
// file: line interface model that feeds timeslot context to the banks
`timescale 1ns/100ps
module tcs_line_model (
    // timeslot context chosen by the bench
    input  wire logic [4:0]  ts,
    input  wire logic [7:0]  asg,
    input  wire logic [7:0]  sig_asg,
    input  wire logic [7:0]  src_sw,
    // context toward the banks
    output logic      [39:0] line_ts_index,
    output logic      [7:0]  line_ts_assigned,
    output logic      [7:0]  line_sig_assigned,
    output logic      [7:0]  line_sig_src_sw,
    output logic      [63:0] line_rx_data,
    output logic      [31:0] line_rx_sig
);
    // =====================================================================
    // context
    // every port walks the same timeslot; received values differ per port so a swap shows
    assign line_ts_index     = {8{ts}};
    assign line_ts_assigned  = asg;
    assign line_sig_assigned = sig_asg;
    assign line_sig_src_sw   = src_sw;
    always_comb begin
        for (int p = 0; p < 8; p++) begin
            line_rx_data[p*8+:8] = 8'ha0 + 8'(p);
            line_rx_sig[p*4+:4]  = 4'(p + 3);
        end
    end
endmodule : tcs_line_model

// [tcs_bank_test.sv]
// file: self-checking bench for the timeslot conditioning and signalling banks
`timescale 1ns/100ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module tcs_bank_test;
    // =====================================================================
    // signals
    localparam int unsigned NP = 4;
    logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [19:0] paddr = 20'h00000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic pready, pslverr, er, jb_fill_req = 1'b0, jb_fill_valid;
    logic [31:0] cond_octets = 32'hd4c3b2a1, line_rx_sig, line_tx_signalling_out;
    logic [4:0] ts = 5'h00, jb_fill_ts = 5'h00;
    logic [7:0] asg = 8'h00, sig_asg = 8'h00, src_sw = 8'h00, jb_fill_octet;
    logic [7:0] line_ts_assigned, line_sig_assigned, line_sig_src_sw;
    logic [2:0] jb_fill_port = 3'h0;
    logic [39:0] line_ts_index;
    logic [63:0] line_rx_data, line_tx_data_out;
    int mismatches = 0, n_tests = 0;
    always #25 clock = ~clock;
    // =====================================================================
    // instances
    tcs_line_model line (.ts(ts), .asg(asg), .sig_asg(sig_asg), .src_sw(src_sw),
        .line_ts_index(line_ts_index), .line_ts_assigned(line_ts_assigned),
        .line_sig_assigned(line_sig_assigned), .line_sig_src_sw(line_sig_src_sw),
        .line_rx_data(line_rx_data), .line_rx_sig(line_rx_sig));
    tcs_bank #(.NUM_PORTS(NP)) dut (.clock(clock), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cond_octets(cond_octets),
        .line_ts_index(line_ts_index), .line_ts_assigned(line_ts_assigned),
        .line_sig_assigned(line_sig_assigned), .line_sig_src_sw(line_sig_src_sw),
        .line_rx_data(line_rx_data), .line_rx_sig(line_rx_sig),
        .line_tx_data_out(line_tx_data_out), .line_tx_signalling_out(line_tx_signalling_out),
        .jb_fill_req(jb_fill_req), .jb_fill_port(jb_fill_port), .jb_fill_ts(jb_fill_ts),
        .jb_fill_valid(jb_fill_valid), .jb_fill_octet(jb_fill_octet));
    // =====================================================================
    // tasks
    function automatic logic [19:0] ea(input logic [19:0] base, input int p, input int t);
        ea = base + 20'(p) * tcs_pkg::PORT_STRIDE + 20'(t) * tcs_pkg::WORD_STRIDE;
    endfunction : ea
    // one apb transfer; waits a setup edge first so back-to-back calls never collide
    task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    // line outputs are registered: the second edge after a change shows it
    task automatic settle();
        repeat (2) @(posedge clock);
    endtask : settle
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        report_and_stop();
    end
    // =====================================================================
    // tests
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        // first and last entries of the map do not alias each other
        apb(1'b1, ea(tcs_pkg::COND_BASE, NP - 1, 31), 32'h00000003);
        apb(1'b1, ea(tcs_pkg::COND_BASE, 0, 0), 32'h00000001);
        apb(1'b1, ea(tcs_pkg::SIG_BASE, NP - 1, 31), 32'h00000009);
        apb(1'b0, ea(tcs_pkg::COND_BASE, NP - 1, 31), 32'h0); `CHK(rd, 32'h00000003)
        apb(1'b0, ea(tcs_pkg::COND_BASE, 0, 0), 32'h0); `CHK(rd, 32'h00000001)
        apb(1'b0, ea(tcs_pkg::SIG_BASE, NP - 1, 31), 32'h0); `CHK(rd, 32'h00000009)
        `CHK(er, 1'b0)
        `CHK(pready, 1'b1)
        // absent port and misaligned word are refused
        apb(1'b1, ea(tcs_pkg::COND_BASE, NP, 0), 32'h00000002); `CHK(er, 1'b1)
        apb(1'b0, ea(tcs_pkg::COND_BASE, NP, 0), 32'h0); `CHK(rd, 32'h00000000)
        apb(1'b0, ea(tcs_pkg::SIG_BASE, 0, 0) + 20'h1, 32'h0); `CHK(er, 1'b1)
        // every selector code drives its octet on the line and into the fill path
        ts <= 5'h05;
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, ea(tcs_pkg::COND_BASE, 1, 5), 32'(c));
            apb(1'b0, ea(tcs_pkg::COND_BASE, 1, 5), 32'h0); `CHK(rd, 32'(c))
            settle(); `CHK(line_tx_data_out[15:8], cond_octets[c*8+:8])
            jb_fill_req <= 1'b1; jb_fill_port <= 3'h1; jb_fill_ts <= 5'h05;
            @(posedge clock); jb_fill_req <= 1'b0;
            @(posedge clock); `CHK(jb_fill_valid, 1'b1)
            `CHK(jb_fill_octet, cond_octets[c*8+:8])
            @(posedge clock);
            `CHK(jb_fill_valid, 1'b0)
        end
        `CHK(line_tx_data_out[63:32], 32'h00000000)
        `CHK(line_tx_signalling_out[31:16], 16'h0000)
        // signalling source selection
        apb(1'b1, ea(tcs_pkg::SIG_BASE, 1, 5), 32'h0000000a);
        apb(1'b0, ea(tcs_pkg::SIG_BASE, 1, 5), 32'h0); `CHK(rd, 32'h0000000a)
        settle(); `CHK(line_tx_signalling_out[7:4], 4'ha)
        asg <= 8'hff; settle(); `CHK(line_tx_signalling_out[7:4], 4'ha)
        `CHK(line_tx_data_out[15:8], 8'ha1)
        sig_asg <= 8'hff; settle(); `CHK(line_tx_signalling_out[7:4], 4'h4)
        src_sw <= 8'hff; settle(); `CHK(line_tx_signalling_out[7:4], 4'ha)
        report_and_stop();
    end
endmodule : tcs_bank_test
